// ==== verilog/ocq_pkg.sv ====
`default_nettype none
package ocq_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_MHZ  = 50;
  localparam int WINDOW_US     = 10;
  localparam int WINDOW_CYC    = WINDOW_US * CLK_FREQ_MHZ;
  localparam int LATCH_CLR_US  = 20;
  localparam int LATCH_CLR_CYC = LATCH_CLR_US * CLK_FREQ_MHZ;
  localparam int WIN_CNT_W     = $clog2(WINDOW_CYC);
  localparam int LATCH_CNT_W   = $clog2(LATCH_CLR_CYC + 1);

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0]  OFF_IRQ_EN  = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_CLR = 8'h10;

  // CTRL fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_LATCH  = 1;
  localparam int CTRL_DELAY  = 2;
  localparam int CTRL_HYST   = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // STATUS fields
  localparam int ST_ALERT   = 0;
  localparam int ST_VERDICT = 1;
  localparam int ST_COUNT   = 4;
  localparam int ST_REQ     = 8;
  localparam int ST_HYST    = 12;

  // Interrupt events
  localparam int IRQ_W       = 3;
  localparam int IRQ_ASSERT  = 0;
  localparam int IRQ_RELEASE = 1;
  localparam int IRQ_OVER    = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ------------------------------------------------------------
  // Three-level select codes and their meaning
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_FLOAT  = 2'h0;
  localparam logic [1:0] SEL_GND    = 2'h1;
  localparam logic [1:0] SEL_SUPPLY = 2'h2;

  localparam int          CNT_W    = 4;
  localparam logic [3:0]  WIN_SHORT = 4'h1;
  localparam logic [3:0]  WIN_MED   = 4'h5;
  localparam logic [3:0]  WIN_LONG  = 4'hA;
  localparam logic [3:0]  HYST_LOW  = 4'h2;
  localparam logic [3:0]  HYST_MID  = 4'h4;
  localparam logic [3:0]  HYST_HIGH = 4'h8;
endpackage : ocq_pkg
`default_nettype wire

// ==== verilog/ocq_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module ocq_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : ocq_sync
`default_nettype wire

// ==== verilog/ocq_window_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module ocq_window_timer
  import ocq_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      window_end
);
  logic [WIN_CNT_W-1:0] cnt_r;
  localparam logic [WIN_CNT_W-1:0] LAST = WIN_CNT_W'(WINDOW_CYC - 1);

  // Free-running; enable and inputs never touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign window_end = (cnt_r == LAST);

  a_window_wrap: assert property (@(posedge pclk)
    disable iff (!presetn) window_end |=> (cnt_r == '0) && !window_end)
    else $error("window timer did not wrap");
endmodule : ocq_window_timer
`default_nettype wire

// ==== verilog/ocq_top.sv ====
// Notes on behaviour
// - All qualification timing uses one 10 us comparison window.
// - Single-window delay: an over verdict at window end asserts alert low.
// - In latched mode a below-threshold verdict leaves the alert state as it was.
// - Medium delay: five consecutive over windows needed before alert.
// - Any below window before the count is reached clears the counter.
// - Longest delay: ten consecutive over windows needed before alert.
// - Delay select: float one window, ground 50 us, supply 100 us.
// - The window runs freely, unsynchronised, with no external control.
// - Each window end produces exactly one over or below verdict.
// - Medium delay adds 40 us, longest adds 90 us versus one window.
// - Hysteresis select: float 2 mV, ground 4 mV, supply 8 mV.
// - Transparent mode: one below window releases the alert.
// - Latch bit high selects latched output, low selects transparent.
// - Latched alert clears once latch is low: at the next below window, or after latch low 20 us with the stored verdict below.
// - Disable clears the window counter; counting restarts from zero.
`timescale 1ns/10ps
`default_nettype none
module ocq_top
  import ocq_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              over_limit_in,
  output logic                   alert_out,
  output logic                   alert_oe,
  output logic      [3:0]        hysteresis_mv,
  output logic                   noise_offset_term,
  output logic                   irq
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic                   over_sync;
  logic                   window_end;
  logic [5:0]             ctrl_r;
  logic [IRQ_W-1:0]       irq_st_r;
  logic [IRQ_W-1:0]       irq_en_r;
  logic [IRQ_W-1:0]       irq_ev;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cnt_nxt;
  logic [CNT_W-1:0]       req_cnt;
  logic [3:0]             hyst_nxt;
  logic [LATCH_CNT_W-1:0] latch_low_r;
  logic                   alert_r;
  logic                   verdict_r;
  logic                   enable;
  logic                   latch_mode;
  logic [1:0]             delay_sel;
  logic [1:0]             hyst_sel;
  logic                   set_alert;
  logic                   rel_window;
  logic                   rel_latch;
  logic                   rel_alert;
  logic                   latch_held;
  logic                   wr_en;
  logic                   rd_setup;
  logic                   addr_hit;
  logic [31:0]            rd_mux;

  // ------------------------------------------------------------
  // Comparator input and window timing
  // ------------------------------------------------------------
  ocq_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (over_limit_in),
    .sync_out (over_sync)
  );

  ocq_window_timer u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .window_end (window_end)
  );

  assign enable     = ctrl_r[CTRL_ENABLE];
  assign latch_mode = ctrl_r[CTRL_LATCH];
  assign delay_sel  = ctrl_r[CTRL_DELAY +: 2];
  assign hyst_sel   = ctrl_r[CTRL_HYST +: 2];

  // ------------------------------------------------------------
  // Select decoding
  // ------------------------------------------------------------
  // Code 3 cannot come from a real three-level pin; it falls back
  // to the floating setting so a stray write stays harmless.
  always_comb begin
    unique case (delay_sel)
      SEL_GND:    req_cnt = WIN_MED;
      SEL_SUPPLY: req_cnt = WIN_LONG;
      default:    req_cnt = WIN_SHORT;
    endcase
  end

  always_comb begin
    unique case (hyst_sel)
      SEL_GND:    hyst_nxt = HYST_MID;
      SEL_SUPPLY: hyst_nxt = HYST_HIGH;
      default:    hyst_nxt = HYST_LOW;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hysteresis_mv     <= HYST_LOW;
      noise_offset_term <= 1'b1;
    end else begin
      hysteresis_mv     <= hyst_nxt;
      noise_offset_term <= (req_cnt == WIN_SHORT);
    end
  end

  // ------------------------------------------------------------
  // Consecutive-window counter
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable) begin
      cnt_nxt = '0;
    end else if (window_end && over_sync) begin
      // Holds at the target so a long overcurrent cannot wrap it
      cnt_nxt = (cnt_r >= req_cnt) ? req_cnt : cnt_r + 1'b1;
    end else if (window_end) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // One verdict per window, kept for the latch release check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_r <= 1'b0;
    end else if (window_end) begin
      verdict_r <= over_sync;
    end
  end

  // ------------------------------------------------------------
  // Latch-low timer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_low_r <= '0;
    end else if (latch_mode) begin
      latch_low_r <= '0;
    end else if (!latch_held) begin
      latch_low_r <= latch_low_r + 1'b1;
    end
  end

  assign latch_held = (latch_low_r == LATCH_CNT_W'(LATCH_CLR_CYC));

  // ------------------------------------------------------------
  // Alert state
  // ------------------------------------------------------------
  // Latency past one window falls out of the count: 4 or 9 extra
  // windows before the set can fire.
  assign set_alert  = enable && window_end && over_sync &&
                      (cnt_r + 1'b1 >= req_cnt);
  assign rel_window = !latch_mode && window_end && !over_sync;
  assign rel_latch  = !latch_mode && latch_held && !verdict_r &&
                      !window_end;
  assign rel_alert  = rel_window || rel_latch;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_r <= 1'b0;
    end else if (!enable) begin
      alert_r <= 1'b0;
    end else if (set_alert) begin
      alert_r <= 1'b1;
    end else if (rel_alert) begin
      alert_r <= 1'b0;
    end
  end

  // Open-drain pin: only ever pulls low
  assign alert_out = 1'b0;
  assign alert_oe  = alert_r;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign irq_ev[IRQ_ASSERT]  = set_alert && !alert_r;
  assign irq_ev[IRQ_RELEASE] = enable && alert_r && !set_alert && rel_alert;
  assign irq_ev[IRQ_OVER]    = enable && window_end && over_sync;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      // A new event beats a clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_st_r[gi] <= IRQ_RST[gi];
        end else if (irq_ev[gi]) begin
          irq_st_r[gi] <= 1'b1;
        end else if (wr_en && paddr == OFF_IRQ_CLR && pwdata[gi]) begin
          irq_st_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irq_st_r & irq_en_r);

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_hit = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                    (paddr == OFF_IRQ_ST) || (paddr == OFF_IRQ_EN) ||
                    (paddr == OFF_IRQ_CLR);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= IRQ_RST;
    end else if (wr_en && paddr == OFF_IRQ_EN) begin
      irq_en_r <= pwdata[IRQ_W-1:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL:   rd_mux[5:0] = ctrl_r;
      OFF_STATUS: begin
        rd_mux[ST_ALERT]          = alert_r;
        rd_mux[ST_VERDICT]        = verdict_r;
        rd_mux[ST_COUNT +: CNT_W] = cnt_r;
        rd_mux[ST_REQ +: CNT_W]   = req_cnt;
        rd_mux[ST_HYST +: 4]      = hysteresis_mv;
      end
      OFF_IRQ_ST: rd_mux[IRQ_W-1:0] = irq_st_r;
      OFF_IRQ_EN: rd_mux[IRQ_W-1:0] = irq_en_r;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Sampled in the setup cycle so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_short_delay_set: assert property (@(posedge pclk)
    disable iff (!presetn) enable && window_end && over_sync &&
    delay_sel == SEL_FLOAT |=> alert_oe)
    else $error("single window over verdict did not assert alert");

  a_latched_hold: assert property (@(posedge pclk)
    disable iff (!presetn) alert_r && latch_mode && enable |=> alert_r)
    else $error("latched alert dropped while latch high");

  a_count_clear: assert property (@(posedge pclk)
    disable iff (!presetn) window_end && !over_sync |=> cnt_r == '0)
    else $error("below window did not clear counter");

  a_medium_count: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(alert_r) && delay_sel == SEL_GND
    |-> cnt_r == WIN_MED)
    else $error("medium delay alert without five windows");

  a_long_count: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(alert_r) && delay_sel == SEL_SUPPLY
    |-> cnt_r == WIN_LONG)
    else $error("long delay alert without ten windows");

  a_transp_release: assert property (@(posedge pclk)
    disable iff (!presetn) alert_r && !latch_mode && window_end &&
    !over_sync |=> !alert_r)
    else $error("transparent alert not released after below window");

  a_disable_reset: assert property (@(posedge pclk)
    disable iff (!presetn) !enable |=> cnt_r == '0 && !alert_oe)
    else $error("disable did not clear counter and alert");

  a_latch_clear: assert property (@(posedge pclk)
    disable iff (!presetn) alert_r && !latch_mode && !verdict_r &&
    !window_end && !$past(latch_mode) && latch_held |=> !alert_r)
    else $error("latch held low did not release alert");

  a_hyst_decode: assert property (@(posedge pclk)
    disable iff (!presetn) hyst_sel == SEL_SUPPLY ##1
    hyst_sel == SEL_SUPPLY |-> hysteresis_mv == HYST_HIGH)
    else $error("supply hysteresis not 8 mV");

  a_irq_assert: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(alert_r) |-> irq_st_r[IRQ_ASSERT])
    else $error("alert assert event not recorded");
endmodule : ocq_top
`default_nettype wire

// ==== sim/ocq_sense_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ocq_sense_model (
  input  wire logic pclk,
  input  wire logic over_cmd,
  input  wire logic alert_out,
  input  wire logic alert_oe,
  output var  logic over_limit_in,
  output logic      alert_n
);
  // ------------------------------------------------------------
  // Comparator verdict and pulled-up alert line
  // ------------------------------------------------------------
  initial over_limit_in = 1'b0;
  // Verdict moves just after an edge, so it never races the sampler
  always @(posedge pclk) over_limit_in <= over_cmd;
  // Released line floats up through the pull-up resistor
  assign alert_n = alert_oe ? alert_out : 1'b1;
endmodule : ocq_sense_model
`default_nettype wire

// ==== sim/ocq_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ocq_top_tb
  import ocq_pkg::*;
  ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, over_cmd, err;
  logic        pready, pslverr, alert_out, alert_oe, nterm, irq;
  logic        over_in, alert_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  hyst_mv;
  logic [31:0] lfsr       = 32'h0001526F;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          base       = 0;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  ocq_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .over_limit_in(over_in),
    .alert_out(alert_out), .alert_oe(alert_oe), .hysteresis_mv(hyst_mv),
    .noise_offset_term(nterm), .irq(irq)
  );
  ocq_sense_model model_u (
    .pclk(pclk), .over_cmd(over_cmd), .alert_out(alert_out),
    .alert_oe(alert_oe), .over_limit_in(over_in), .alert_n(alert_n)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] req_cnt(input logic [1:0] c);
    return (c == SEL_GND) ? WIN_MED : (c == SEL_SUPPLY) ? WIN_LONG : WIN_SHORT;
  endfunction : req_cnt

  function automatic logic [3:0] hyst_of(input logic [1:0] c);
    return (c == SEL_GND) ? HYST_MID : (c == SEL_SUPPLY) ? HYST_HIGH :
           HYST_LOW;
  endfunction : hyst_of

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_al(input logic e);
    chk(32'(alert_oe), 32'(e));
    chk(32'(alert_n), 32'(!e));
  endtask : chk_al

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic cfg(input logic en, input logic lt, input logic [1:0] dl);
    apb(1'b1, OFF_CTRL, {28'h0, dl, lt, en});
  endtask : cfg

  // Steps to mid-window, far from the verdict edge and the sync delay
  task automatic win(input int k);
    repeat (k) begin
      @(posedge pclk);
      while ((cyc - base) % 500 != 250) @(posedge pclk);
    end
  endtask : win

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Watchdog, sized well above the roughly 30k cycles of tests
  // ------------------------------------------------------------
  initial begin
    #(100000 * 20);
    err_total++;
    summarize();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    int n;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    over_cmd = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'hFC, rnd());
    chk(32'(err), 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFF_CTRL, {26'h0, 2'(c), 2'(c), 2'h0});
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(32'(rd[11:8]), 32'(req_cnt(2'(c))));
      chk(32'(hyst_mv), 32'(hyst_of(2'(c))));
      chk(32'(nterm), 32'(req_cnt(2'(c)) == WIN_SHORT));
      chk(32'(pready), 32'h1);
    end
    done("reset_decode");
    // Single window: first verdict edge fixes our view of the phase
    apb(1'b1, OFF_IRQ_EN, 32'h7);
    cfg(1'b1, 1'b0, SEL_FLOAT);
    over_cmd <= 1'b1;
    n = 0;
    while (alert_oe !== 1'b1 && n < 700) begin
      @(posedge pclk);
      n++;
    end
    base = cyc;
    chk(32'(n < 700), 32'h1);
    chk(32'(irq), 32'h1);
    win(1);
    chk_al(1'b1);
    over_cmd <= 1'b0;
    win(1);
    chk_al(1'b0);
    win(1);
    chk_al(1'b0);
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    done("single_window");
    for (int c = 1; c < 3; c++) begin
      cfg(1'b1, 1'b0, 2'(c));
      over_cmd <= 1'b1;
      win(int'(req_cnt(2'(c))) - 1);
      chk_al(1'b0);
      win(1);
      chk_al(1'b1);
      over_cmd <= 1'b0;
      win(1);
    end
    done("delays");
    // Runs of one to four over windows, each broken by a below window
    cfg(1'b1, 1'b0, SEL_GND);
    repeat (4) begin
      over_cmd <= 1'b1;
      win(1 + int'(rnd() % 32'd4));
      over_cmd <= 1'b0;
      win(1);
      chk_al(1'b0);
    end
    over_cmd <= 1'b1;
    win(5);
    chk_al(1'b1);
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFF_IRQ_EN, 32'h7);
    chk(32'(irq), 32'h1);
    over_cmd <= 1'b0;
    win(1);
    done("counter_reset_irq");
    cfg(1'b1, 1'b1, SEL_FLOAT);
    over_cmd <= 1'b1;
    win(1);
    chk_al(1'b1);
    over_cmd <= 1'b0;
    win(2);
    chk_al(1'b1);
    over_cmd <= 1'b1;
    // Latch held low for well over 20 us from here on
    cfg(1'b1, 1'b0, SEL_FLOAT);
    win(3);
    chk_al(1'b1);
    over_cmd <= 1'b0;
    win(1);
    chk_al(1'b0);
    done("latch");
    // Disable mid-count: a stale count would fire three windows early
    cfg(1'b1, 1'b0, SEL_GND);
    over_cmd <= 1'b1;
    win(3);
    cfg(1'b0, 1'b0, SEL_GND);
    win(1);
    cfg(1'b1, 1'b0, SEL_GND);
    win(4);
    chk_al(1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[7:4]), 32'h4);
    win(1);
    chk_al(1'b1);
    win(1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[7:4]), 32'(WIN_MED));
    over_cmd <= 1'b0;
    win(1);
    done("disable");
    summarize();
  end
endmodule : ocq_top_tb
`default_nettype wire
